/* logic/acd_datapath.sv */
// accumulator, carry, shifts and aux register file of the fixed-point core.
// assumes decode drives instr synchronous to clk and holds nothing while busy is high.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module acd_datapath
(
   input wire logic clk, // core clock, 10 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire acd_pkg::acd_instr_type instr, // instruction from decode
   input wire logic [31:0] product_in, // scaled product register
   output acd_pkg::acd_out_type dout, // results to the core
   input wire logic [4:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // response valid
   input wire logic s_axi_bready, // response ready
   input wire logic [4:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready // read data ready
);
   acd_pkg::acd_state_type st; // registered state
   acd_pkg::acd_state_type nx; // next state
   logic taken; // new instruction accepted this cycle
   logic run; // an operation executes this cycle
   acd_pkg::acd_op_type cur_op; // operation executing
   logic [31:0] opnd; // selected operand
   logic [31:0] bx; // operand as added (inverted for subtract)
   logic cin; // carry into bit 0
   logic [32:0] sum; // 33-bit sum, top bit is carry out
   logic ov; // signed overflow of sum
   logic [32:0] shres; // carry and accumulator after one shift
   logic [31:0] hi_shifted; // accumulator shifted for high store
   logic [15:0] lo_shifted; // low half shifted for low store
   logic [15:0] cur_ar; // pointed register
   logic [15:0] ld_val; // aux load value

   // one in-place shift or rotate through carry
   function automatic logic [32:0] shift_step(input acd_pkg::acd_op_type op,
      input logic [31:0] a, input logic c, input logic sgn);
      logic [32:0] r;
      r = {c, a};
      case (op)
         acd_pkg::ACD_SHL: r = {a[31], a[30:0], 1'b0}; // RULE15 RULE12
         acd_pkg::ACD_SHR: r = {a[0], (sgn & a[31]), a[31:1]}; // RULE13 RULE14 RULE12
         acd_pkg::ACD_RTL: r = {a[31], a[30:0], c}; // RULE12
         acd_pkg::ACD_RTR: r = {a[0], c, a[31:1]}; // RULE12
         default: r = {c, a};
      endcase
      return r;
   endfunction

   function automatic logic is_shift(input acd_pkg::acd_op_type op);
      return (op == acd_pkg::ACD_SHL) || (op == acd_pkg::ACD_SHR) ||
             (op == acd_pkg::ACD_RTL) || (op == acd_pkg::ACD_RTR);
   endfunction

   // datapath arithmetic, shared by every arithmetic op
   always_comb
   begin
      // operand mux; aux registers feed the arithmetic unit too
      case (instr.src)
         acd_pkg::ACD_SRC_PROD: opnd = product_in;
         acd_pkg::ACD_SRC_ACC: opnd = st.acc;
         acd_pkg::ACD_SRC_AUX: opnd = {16'h0000, st.ar[instr.arsel]}; // RULE19
         acd_pkg::ACD_SRC_IMM: opnd = {16'h0000, instr.imm};
         default: opnd = instr.data;
      endcase
      bx = opnd;
      cin = 1'b0;
      case (instr.op)
         acd_pkg::ACD_SUB: {bx, cin} = {~opnd, 1'b1}; // borrow-free subtract
         acd_pkg::ACD_ADCY: cin = st.carry; // RULE3
         acd_pkg::ACD_SBBW: {bx, cin} = {~opnd, st.carry}; // RULE3
         acd_pkg::ACD_ADD_HI: bx = {opnd[15:0], 16'h0000};
         acd_pkg::ACD_SUB_HI: {bx, cin} = {~{opnd[15:0], 16'h0000}, 1'b1};
         default: cin = 1'b0;
      endcase
      sum = {1'b0, st.acc} + {1'b0, bx} + {32'h00000000, cin}; // RULE22
      ov = (st.acc[31] == bx[31]) && (sum[31] != st.acc[31]);
      // store path shifters, accumulator untouched
      hi_shifted = st.acc << instr.shift; // RULE10
      lo_shifted = st.acc[15:0] << instr.shift; // RULE11
      cur_ar = st.ar[st.ptr];
      case (instr.src)
         acd_pkg::ACD_SRC_ACC: ld_val = st.acc[15:0];
         acd_pkg::ACD_SRC_PROD: ld_val = product_in[15:0];
         acd_pkg::ACD_SRC_IMM: ld_val = instr.imm;
         default: ld_val = instr.data[15:0];
      endcase
   end

   // next-state logic for the datapath and the bus slave
   always_comb
   begin
      nx = st;
      nx.store_valid = 1'b0;
      taken = instr.valid && (st.rep_left == 4'h0);
      run = 1'b0;
      cur_op = acd_pkg::ACD_NOP;
      shres = 33'h000000000;
      // repeat engine: replay the held shift while the count runs
      if (st.rep_left != 4'h0)
      begin
         run = 1'b1;
         cur_op = st.rep_op;
         nx.rep_left = st.rep_left - 4'h1; // RULE16
      end
      else if (taken)
      begin
         run = 1'b1;
         cur_op = instr.op;
         if (is_shift(instr.op))
         begin
            nx.rep_left = instr.rep_cnt; // RULE16
            nx.rep_op = instr.op;
         end
      end
      // bus writes first so that hardware events below win
      if (st.aw_got && st.w_got && !st.bvalid)
      begin
         nx.bvalid = 1'b1;
         nx.bresp = acd_pkg::ACD_RESP_OKAY;
         case (st.waddr)
            acd_pkg::ACD_REG_CTRL:
               if (st.wstrb[0])
               begin
                  nx.sgn = st.wdata[acd_pkg::ACD_CTRL_SIGN_BIT];
                  nx.sat = st.wdata[acd_pkg::ACD_CTRL_SAT_BIT];
               end
            acd_pkg::ACD_REG_STATUS:
               if (st.wstrb[0] && st.wdata[acd_pkg::ACD_STAT_OV_BIT])
                  nx.ovf = 1'b0; // write one clears
            acd_pkg::ACD_REG_ACC, acd_pkg::ACD_REG_STORE: nx.bresp = acd_pkg::ACD_RESP_OKAY;
            default: nx.bresp = acd_pkg::ACD_RESP_SLVERR; // unmapped
         endcase
         nx.aw_got = 1'b0;
         nx.w_got = 1'b0;
      end
      // address update unit on the pointed register, no arithmetic unit
      if (taken)
      begin
         case (instr.au)
            acd_pkg::ACD_AU_INC: nx.ar[st.ptr] = cur_ar + 16'h0001; // RULE20
            acd_pkg::ACD_AU_DEC: nx.ar[st.ptr] = cur_ar - 16'h0001; // RULE20
            acd_pkg::ACD_AU_ADD0: nx.ar[st.ptr] = cur_ar + st.ar[0]; // RULE20
            acd_pkg::ACD_AU_SUB0: nx.ar[st.ptr] = cur_ar - st.ar[0]; // RULE20
            default: nx.ar[st.ptr] = nx.ar[st.ptr];
         endcase
      end
      // operation execute
      if (run)
      begin
         case (cur_op)
            acd_pkg::ACD_LOAD_ACC, acd_pkg::ACD_AND, acd_pkg::ACD_OR, acd_pkg::ACD_XOR:
            begin
               // carry held for loads and logic ops
               case (cur_op)
                  acd_pkg::ACD_AND: nx.acc = st.acc & opnd; // RULE2
                  acd_pkg::ACD_OR: nx.acc = st.acc | opnd; // RULE2
                  acd_pkg::ACD_XOR: nx.acc = st.acc ^ opnd; // RULE2
                  default: nx.acc = opnd; // RULE2
               endcase
            end
            acd_pkg::ACD_ADD, acd_pkg::ACD_SUB, acd_pkg::ACD_ADCY, acd_pkg::ACD_SBBW,
            acd_pkg::ACD_ADD_HI, acd_pkg::ACD_SUB_HI:
            begin
               nx.acc = sum[31:0]; // RULE8
               if (ov)
               begin
                  nx.ovf = 1'b1; // RULE21
                  if (st.sat)
                     nx.acc = st.acc[31] ? acd_pkg::ACD_SAT_NEG : acd_pkg::ACD_SAT_POS; // RULE21
               end
               if (cur_op == acd_pkg::ACD_ADD_HI)
               begin
                  if (sum[32])
                     nx.carry = 1'b1; // RULE4
               end
               else if (cur_op == acd_pkg::ACD_SUB_HI)
               begin
                  if (!sum[32])
                     nx.carry = 1'b0; // RULE4
               end
               else
                  nx.carry = sum[32]; // RULE1 RULE22
            end
            acd_pkg::ACD_SHL, acd_pkg::ACD_SHR, acd_pkg::ACD_RTL, acd_pkg::ACD_RTR:
            begin
               shres = shift_step(cur_op, st.acc, st.carry, st.sgn);
               {nx.carry, nx.acc} = shres; // RULE1 RULE12
            end
            acd_pkg::ACD_CSET: nx.carry = 1'b1; // RULE6
            acd_pkg::ACD_CCLR: nx.carry = 1'b0; // RULE6
            acd_pkg::ACD_LOAD_STATUS:
            begin
               nx.carry = opnd[acd_pkg::ACD_STW_C_BIT]; // RULE6
               nx.sgn = opnd[acd_pkg::ACD_STW_SIGN_BIT];
               nx.sat = opnd[acd_pkg::ACD_STW_SAT_BIT];
               nx.ptr = opnd[acd_pkg::ACD_STW_PTR_LSB +: 3]; // RULE18
            end
            acd_pkg::ACD_STORE_HI:
            begin
               nx.store_data = hi_shifted[31:16]; // RULE9 RULE10
               nx.store_valid = 1'b1;
            end
            acd_pkg::ACD_STORE_LO:
            begin
               nx.store_data = lo_shifted; // RULE9 RULE11
               nx.store_valid = 1'b1;
            end
            acd_pkg::ACD_LOAD_AR: nx.ar[instr.arsel] = ld_val; // RULE18 RULE17
            acd_pkg::ACD_LOAD_ARP: nx.ptr = ld_val[2:0]; // RULE18 RULE17
            acd_pkg::ACD_STORE_AR:
            begin
               nx.store_data = st.ar[instr.arsel]; // RULE19
               nx.store_valid = 1'b1;
            end
            default: nx.carry = nx.carry; // control ops keep carry
         endcase
      end
      nx.no_carry = ~nx.carry; // RULE5
      nx.busy = (nx.rep_left != 4'h0);
      nx.daddr = nx.ar[nx.ptr]; // RULE17
      // bus slave: capture address and data in either order
      if (s_axi_awvalid && st.awready)
      begin
         nx.aw_got = 1'b1;
         nx.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready)
      begin
         nx.w_got = 1'b1;
         nx.wdata = s_axi_wdata;
         nx.wstrb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready)
         nx.bvalid = 1'b0;
      nx.awready = !nx.aw_got && !nx.bvalid;
      nx.wready = !nx.w_got && !nx.bvalid;
      // read channel: one outstanding read, answered next cycle
      if (st.rvalid && s_axi_rready)
         nx.rvalid = 1'b0;
      if (s_axi_arvalid && st.arready)
      begin
         nx.rvalid = 1'b1;
         nx.rresp = acd_pkg::ACD_RESP_OKAY;
         case (s_axi_araddr)
            acd_pkg::ACD_REG_CTRL: nx.rdata = {30'h00000000, st.sat, st.sgn};
            acd_pkg::ACD_REG_STATUS: nx.rdata = {27'h0000000, st.ptr, st.ovf, st.carry};
            acd_pkg::ACD_REG_ACC: nx.rdata = st.acc;
            acd_pkg::ACD_REG_STORE: nx.rdata = {16'h0000, st.store_data};
            default:
            begin
               nx.rdata = 32'h00000000;
               nx.rresp = acd_pkg::ACD_RESP_SLVERR;
            end
         endcase
      end
      nx.arready = !nx.rvalid;
   end

   // state register; reset gives carry one and an idle slave
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st <= '0;
         st.carry <= acd_pkg::ACD_CARRY_RST; // RULE7
         st.no_carry <= ~acd_pkg::ACD_CARRY_RST;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
      end
      else
         st <= nx;
   end

   // outputs straight from state flops
   assign dout = '{busy: st.busy, carry: st.carry, no_carry: st.no_carry, ovf: st.ovf,
                   store_valid: st.store_valid, store_data: st.store_data, daddr: st.daddr};
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   // checks on the datapath behaviour
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_rst_carry;
      @(posedge clk) disable iff (1'b0) sys_rst |=> st.carry && !st.no_carry;
   endproperty
   a_rst_carry: assert property (p_rst_carry) else $error("carry not one after reset"); // RULE7

   property p_logic_keeps;
      taken && (instr.op inside {acd_pkg::ACD_AND, acd_pkg::ACD_OR, acd_pkg::ACD_XOR,
         acd_pkg::ACD_LOAD_ACC}) |=> $stable(st.carry);
   endproperty
   a_logic_keeps: assert property (p_logic_keeps) else $error("logic op moved carry"); // RULE2

   property p_add_with_carry_op;
      taken && instr.op == acd_pkg::ACD_ADCY && instr.src == acd_pkg::ACD_SRC_DATA && !st.sat
      |=> st.acc == $past(st.acc) + $past(instr.data) + {31'h0, $past(st.carry)};
   endproperty
   a_add_with_carry_op: assert property (p_add_with_carry_op) else $error("add with carry result wrong"); // RULE3

   property p_addhi_keep;
      taken && instr.op == acd_pkg::ACD_ADD_HI && st.carry |=> st.carry;
   endproperty
   a_addhi_keep: assert property (p_addhi_keep) else $error("high add cleared carry"); // RULE4

   property p_cond;
      st.no_carry == !st.carry;
   endproperty
   a_cond: assert property (p_cond) else $error("carry conditions disagree"); // RULE5

   property p_store_lo;
      taken && instr.op == acd_pkg::ACD_STORE_LO |=> st.store_valid && $stable(st.acc) &&
         ((st.store_data & ((16'h0001 << $past(instr.shift)) - 16'h0001)) == 16'h0000);
   endproperty
   a_store_lo: assert property (p_store_lo) else $error("low store not zero filled"); // RULE11

   property p_sfl;
      taken && instr.op == acd_pkg::ACD_SHL
      |=> !st.acc[0] && st.carry == $past(st.acc[31]);
   endproperty
   a_sfl: assert property (p_sfl) else $error("left shift wrong"); // RULE15

   property p_sfr;
      taken && instr.op == acd_pkg::ACD_SHR
      |=> st.acc[31] == ($past(st.sgn) & $past(st.acc[31])) && st.carry == $past(st.acc[0]);
   endproperty
   a_sfr: assert property (p_sfr) else $error("right shift wrong"); // RULE13

   property p_repeat;
      taken && is_shift(instr.op) && instr.rep_cnt == 4'h2 |=> st.busy [*2] ##1 !st.busy;
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat length wrong"); // RULE16

   property p_inc;
      taken && instr.au == acd_pkg::ACD_AU_INC && instr.op != acd_pkg::ACD_LOAD_AR
      |=> st.ar[$past(st.ptr)] == $past(st.ar[st.ptr]) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("address step wrong"); // RULE20

   c_add_with_carry_op: cover property (taken && instr.op == acd_pkg::ACD_ADCY && st.carry);
   c_repeat: cover property (taken && instr.op == acd_pkg::ACD_SHR && instr.rep_cnt != 4'h0);
   c_sat: cover property (st.sat ##1 st.ovf);
   c_wr: cover property (st.bvalid && s_axi_bready);
endmodule // acd_datapath
`default_nettype wire

/* logic/acd_pkg.sv */
// Function
// RULE1: arithmetic and single-bit shifts update carry
// RULE2: loads, logic and control ops keep carry
// RULE3: add/subtract with carry use previous carry
// RULE4: high-half add only sets, subtract only clears
// RULE5: carry set/clear conditions come from carry
// RULE6: set, clear and status load write carry
// RULE7: reset forces carry to one
// RULE8: 32-bit accumulator, halves stored separately
// RULE9: store shift 0-7 on bus path only
// RULE10: high store fills from low half top
// RULE11: low store fills vacated bits with zero
// RULE12: shifts and rotates pass outgoing bit to carry
// RULE13: sign mode one: arithmetic right shift
// RULE14: sign mode zero: logical right shift
// RULE15: left shift inserts zero, ignores sign mode
// RULE16: shifts repeat under single repeat
// RULE17: eight aux registers picked by 3-bit pointer
// RULE18: aux regs and pointer load from four sources
// RULE19: aux regs storable and usable as operand
// RULE20: address unit steps pointer register by 1 or zero-reg
// RULE21: saturation mode clamps accumulator, sets overflow
// RULE22: carry is bit-31 carry out, no borrow sets
// package of constants and carried types for the accumulator datapath.
// assumes one core clock; decode presents one instruction per cycle when not busy.
package acd_pkg;
   // register byte offsets on the control bus
   localparam logic [4:0] ACD_REG_CTRL = 5'h00; // sign/saturation mode, read-write
   localparam logic [4:0] ACD_REG_STATUS = 5'h04; // carry, overflow, pointer
   localparam logic [4:0] ACD_REG_ACC = 5'h08; // accumulator, read only
   localparam logic [4:0] ACD_REG_STORE = 5'h0c; // last store word, read only
   // field positions
   localparam int ACD_CTRL_SIGN_BIT = 0; // sign-extend mode
   localparam int ACD_CTRL_SAT_BIT = 1; // saturation mode
   localparam int ACD_STAT_C_BIT = 0; // carry
   localparam int ACD_STAT_OV_BIT = 1; // overflow, write one clears
   localparam int ACD_STAT_PTR_LSB = 2; // pointer, three bits
   // status word layout used by the status load operation
   localparam int ACD_STW_C_BIT = 9;
   localparam int ACD_STW_SIGN_BIT = 10;
   localparam int ACD_STW_SAT_BIT = 11;
   localparam int ACD_STW_PTR_LSB = 13;
   // values after reset, saturation limits and bus response codes
   localparam logic ACD_CARRY_RST = 1'b1;
   localparam logic [31:0] ACD_SAT_POS = 32'h7fffffff;
   localparam logic [31:0] ACD_SAT_NEG = 32'h80000000;
   localparam logic [1:0] ACD_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACD_RESP_SLVERR = 2'h2;
   // operations issued by decode
   typedef enum logic [4:0] {
      ACD_NOP, ACD_LOAD_ACC, ACD_ADD, ACD_SUB, ACD_ADCY, ACD_SBBW, ACD_ADD_HI, ACD_SUB_HI,
      ACD_AND, ACD_OR, ACD_XOR, ACD_SHL, ACD_SHR, ACD_RTL, ACD_RTR, ACD_CSET, ACD_CCLR,
      ACD_LOAD_STATUS, ACD_STORE_HI, ACD_STORE_LO, ACD_LOAD_AR, ACD_LOAD_ARP, ACD_STORE_AR
   } acd_op_type;
   // operand sources
   typedef enum logic [2:0] {ACD_SRC_DATA, ACD_SRC_PROD, ACD_SRC_ACC, ACD_SRC_AUX,
                             ACD_SRC_IMM} acd_src_type;
   // address update modes for the pointed register
   typedef enum logic [2:0] {ACD_AU_NONE, ACD_AU_INC, ACD_AU_DEC, ACD_AU_ADD0,
                             ACD_AU_SUB0} acd_au_type;
   // one instruction from decode
   typedef struct packed {
      logic valid; // instruction present
      acd_op_type op; // operation
      acd_src_type src; // operand source
      acd_au_type au; // address update mode
      logic [2:0] arsel; // aux register for load/store/operand
      logic [3:0] rep_cnt; // extra repeats of a shift
      logic [2:0] shift; // store shift 0..7
      logic [31:0] data; // scaled data-bus operand
      logic [15:0] imm; // immediate field
   } acd_instr_type;
   // datapath results to the core
   typedef struct packed {
      logic busy; // repeat running, instructions ignored
      logic carry; // carry-set condition
      logic no_carry; // carry-clear condition
      logic ovf; // overflow flag
      logic store_valid; // store word present, one cycle
      logic [15:0] store_data; // word for data memory
      logic [15:0] daddr; // indirect data address
   } acd_out_type;
   // whole module state
   typedef struct packed {
      logic [31:0] acc;
      logic carry, no_carry, ovf, sgn, sat;
      logic [2:0] ptr;
      logic [7:0][15:0] ar;
      logic [3:0] rep_left;
      acd_op_type rep_op;
      logic busy, store_valid;
      logic [15:0] store_data, daddr;
      logic awready, wready, aw_got, w_got, bvalid, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [4:0] waddr;
      logic [31:0] wdata, rdata;
      logic [3:0] wstrb;
   } acd_state_type;
endpackage

/* testbench/acd_decoder_model.sv */
// decoder model: offers one instruction at a time to the datapath.
// assumes busy comes from flops and the bench calls issue after an edge.
`timescale 1ns/1ps
`default_nettype none
module acd_decoder_model
(
   input wire logic clk, // core clock
   input wire logic busy, // repeat running in the datapath
   output var acd_pkg::acd_instr_type instr // instruction to the datapath
);
   initial instr = '0; // idle until asked
   // offer for exactly one edge; nowait skips the busy check on purpose
   task automatic issue(input acd_pkg::acd_instr_type v, input logic nowait);
      if (!nowait)
      begin
         do @(negedge clk); while (busy); // a real decoder holds off while busy
      end
      @(posedge clk);
      instr <= v;
      @(posedge clk);
      instr <= '0; // release, else it would be taken twice
   endtask
endmodule // acd_decoder_model
`default_nettype wire

/* testbench/tb_top.sv */
// bench for the accumulator datapath: a table of ops, then hand tests.
// assumes the decoder model issues ops; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {
      acd_pkg::acd_op_type op; // operation
      acd_pkg::acd_src_type src; // operand source
      acd_pkg::acd_au_type au; // address update
      logic [2:0] sel; // aux select, also store shift
      logic [31:0] d; // data and immediate
      logic [31:0] acc; // expected accumulator
      logic c; // expected carry
      logic [15:0] w; // expected store word, else data address
   } acd_row_type;
   localparam acd_pkg::acd_src_type sd = acd_pkg::ACD_SRC_DATA;
   localparam acd_pkg::acd_src_type si = acd_pkg::ACD_SRC_IMM;
   localparam acd_pkg::acd_au_type an = acd_pkg::ACD_AU_NONE;
   logic clk = 1'h0; // core clock
   logic sys_rst = 1'h1; // reset, high
   logic [4:0] awa = 5'h0, ara = 5'h0; // bus addresses
   logic [31:0] wd = 32'h0, rdata, rd, pr = 32'hffffffff; // bus data, product
   logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0; // master side
   logic awr, wr, bv, arr, rv, st; // slave side; st is the expected store flag
   logic [1:0] bresp, rresp, rs; // responses
   acd_pkg::acd_instr_type instr; // from decoder model
   acd_pkg::acd_out_type dout; // datapath results
   int n_fail = 0, n_tests = 0, cyc = 0; // counters
   acd_row_type rows [0:28] = '{
      '{acd_pkg::ACD_CCLR, sd, an, 3'h0, 32'h0, 32'h0, 1'h0, 16'h0},
      '{acd_pkg::ACD_LOAD_ACC, sd, an, 3'h0, 32'h80000001, 32'h80000001, 1'h0, 16'h0},
      '{acd_pkg::ACD_SHL, sd, an, 3'h0, 32'h0, 32'h2, 1'h1, 16'h0},
      '{acd_pkg::ACD_SHR, sd, an, 3'h0, 32'h0, 32'h1, 1'h0, 16'h0},
      '{acd_pkg::ACD_RTR, sd, an, 3'h0, 32'h0, 32'h0, 1'h1, 16'h0},
      '{acd_pkg::ACD_RTL, sd, an, 3'h0, 32'h0, 32'h1, 1'h0, 16'h0},
      '{acd_pkg::ACD_ADD, acd_pkg::ACD_SRC_PROD, an, 3'h0, 32'h0, 32'h0, 1'h1, 16'h0},
      '{acd_pkg::ACD_ADCY, sd, an, 3'h0, 32'h5, 32'h6, 1'h0, 16'h0},
      '{acd_pkg::ACD_SBBW, sd, an, 3'h0, 32'h5, 32'h0, 1'h1, 16'h0},
      '{acd_pkg::ACD_XOR, sd, an, 3'h0, 32'hffff, 32'hffff, 1'h1, 16'h0},
      '{acd_pkg::ACD_CCLR, sd, an, 3'h0, 32'h0, 32'hffff, 1'h0, 16'h0},
      '{acd_pkg::ACD_ADD_HI, sd, an, 3'h0, 32'hffff, 32'hffffffff, 1'h0, 16'h0},
      '{acd_pkg::ACD_ADD_HI, sd, an, 3'h0, 32'h1, 32'hffff, 1'h1, 16'h0},
      '{acd_pkg::ACD_ADD_HI, sd, an, 3'h0, 32'h1, 32'h1ffff, 1'h1, 16'h0},
      '{acd_pkg::ACD_SUB_HI, sd, an, 3'h0, 32'h2, 32'hffffffff, 1'h0, 16'h0},
      '{acd_pkg::ACD_SUB_HI, sd, an, 3'h0, 32'hffff, 32'hffff, 1'h0, 16'h0},
      '{acd_pkg::ACD_LOAD_ACC, sd, an, 3'h0, 32'h1234abcd, 32'h1234abcd, 1'h0, 16'h0},
      '{acd_pkg::ACD_STORE_HI, sd, an, 3'h0, 32'h0, 32'h1234abcd, 1'h0, 16'h1234},
      '{acd_pkg::ACD_STORE_HI, sd, an, 3'h7, 32'h0, 32'h1234abcd, 1'h0, 16'h1a55},
      '{acd_pkg::ACD_STORE_LO, sd, an, 3'h7, 32'h0, 32'h1234abcd, 1'h0, 16'he680},
      '{acd_pkg::ACD_LOAD_STATUS, sd, an, 3'h0, 32'h2200, 32'h1234abcd, 1'h1, 16'h0},
      '{acd_pkg::ACD_LOAD_ARP, si, an, 3'h0, 32'h3, 32'h1234abcd, 1'h1, 16'h0},
      '{acd_pkg::ACD_LOAD_AR, si, an, 3'h3, 32'h100, 32'h1234abcd, 1'h1, 16'h100},
      '{acd_pkg::ACD_LOAD_AR, si, an, 3'h0, 32'h10, 32'h1234abcd, 1'h1, 16'h100},
      '{acd_pkg::ACD_NOP, sd, acd_pkg::ACD_AU_INC, 3'h0, 32'h0, 32'h1234abcd, 1'h1, 16'h101},
      '{acd_pkg::ACD_NOP, sd, acd_pkg::ACD_AU_ADD0, 3'h0, 32'h0, 32'h1234abcd, 1'h1, 16'h111},
      '{acd_pkg::ACD_NOP, sd, acd_pkg::ACD_AU_DEC, 3'h0, 32'h0, 32'h1234abcd, 1'h1, 16'h110},
      '{acd_pkg::ACD_STORE_AR, sd, an, 3'h3, 32'h0, 32'h1234abcd, 1'h1, 16'h110},
      '{acd_pkg::ACD_LOAD_ACC, acd_pkg::ACD_SRC_AUX, an, 3'h0, 32'h0, 32'h10, 1'h1, 16'h110}};
   acd_datapath dut_u (.clk(clk), .sys_rst(sys_rst), .instr(instr), .product_in(pr),
      .dout(dout), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr));
   acd_decoder_model p_u (.clk(clk), .busy(dout.busy), .instr(instr));
   always #50 clk = ~clk; // 10 MHz
   // word compare; bits are widened so unknowns still fail
   task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_b(input string nm, input logic e, input logic g);
      chk_w(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bus write: both channels offered together, each dropped when taken
   task automatic axw(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wr) wv <= 1'h0;
      end
      while (!bv);
      br <= 1'h0;
      chk_w("bresp", 32'h0, {30'h0, bresp});
   endtask
   task automatic axr(input logic [4:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end
      while (!rv);
      rr <= 1'h0;
      rd = rdata;
      rs = rresp;
   endtask
   task automatic racc(input logic [31:0] e);
      axr(acd_pkg::ACD_REG_ACC);
      chk_w("acc", e, rd);
   endtask
   function automatic acd_pkg::acd_instr_type mk(input acd_row_type r, input logic [3:0] n);
      mk = '0;
      mk.valid = 1'h1;
      mk.op = r.op;
      mk.src = r.src;
      mk.au = r.au;
      mk.arsel = r.sel;
      mk.shift = r.sel;
      mk.rep_cnt = n;
      mk.data = r.d;
      mk.imm = r.d[15:0];
   endfunction
   task automatic op1(input acd_pkg::acd_op_type o, input logic [31:0] d, input logic [3:0] n,
      input logic nw);
      p_u.issue(mk('{o, sd, an, 3'h0, d, 32'h0, 1'h0, 16'h0}, n), nw);
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         n_fail++;
         summarize;
      end
   end
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      @(negedge clk);
      chk_b("carry", 1'h1, dout.carry);
      axr(acd_pkg::ACD_REG_CTRL);
      chk_w("ctrl", 32'h0, rd);
      axr(acd_pkg::ACD_REG_STATUS);
      chk_w("status", 32'h1, rd);
      foreach (rows[i])
      begin
         p_u.issue(mk(rows[i], 4'h0), 1'h0);
         @(negedge clk);
         st = rows[i].op inside {acd_pkg::ACD_STORE_HI, acd_pkg::ACD_STORE_LO,
            acd_pkg::ACD_STORE_AR};
         chk_b("carry", rows[i].c, dout.carry);
         chk_b("no_carry", !rows[i].c, dout.no_carry);
         chk_b("store_valid", st, dout.store_valid);
         chk_w("word", {16'h0, rows[i].w}, {16'h0, st ? dout.store_data : dout.daddr});
         racc(rows[i].acc);
      end
      // arithmetic right shift repeated; an op offered meanwhile is dropped
      axw(acd_pkg::ACD_REG_CTRL, 32'h1);
      op1(acd_pkg::ACD_LOAD_ACC, 32'h80000000, 4'h0, 1'h0);
      op1(acd_pkg::ACD_SHR, 32'h0, 4'h2, 1'h0);
      @(negedge clk);
      chk_b("busy", 1'h1, dout.busy);
      op1(acd_pkg::ACD_LOAD_ACC, 32'h0, 4'h0, 1'h1);
      racc(32'hf0000000);
      chk_b("carry", 1'h0, dout.carry);
      // saturation, then the sticky flag cleared over the bus
      axw(acd_pkg::ACD_REG_CTRL, 32'h2);
      op1(acd_pkg::ACD_LOAD_ACC, 32'h7fffffff, 4'h0, 1'h0);
      op1(acd_pkg::ACD_ADD, 32'h1, 4'h0, 1'h0);
      racc(32'h7fffffff);
      chk_b("ovf", 1'h1, dout.ovf);
      axw(acd_pkg::ACD_REG_STATUS, 32'h2);
      @(negedge clk);
      chk_b("ovf", 1'h0, dout.ovf);
      axr(5'h10);
      chk_w("rresp", 32'h2, {30'h0, rs});
      chk_w("rdata", 32'h0, rd);
      // second reset in mid-run
      @(posedge clk);
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      @(negedge clk);
      chk_b("carry", 1'h1, dout.carry);
      racc(32'h0);
      summarize;
   end
endmodule // tb_top
`default_nettype wire
